// ### dv/bapc_host_model.sv
// behavioural host serial master driving the link pins of the block
`timescale 1ns/1ns
module bapc_host_model
  import bapc_pkg::*;
(
  input  wire logic i_clock_polarity_select,
  input  wire logic i_dout,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_din
);
  // ----------------------------------------------------------------------
  // idle state: clock stands at the polarity level between frames
  // ----------------------------------------------------------------------
  initial begin
    o_cs_n = 1'b1;
    o_din  = 1'b0;
    o_sclk = 1'b0;
  end

  // idle level follows the strap only while no frame runs
  always @(i_clock_polarity_select) begin
    if (o_cs_n) begin
      o_sclk = i_clock_polarity_select;
    end
  end

  // one full duplex byte, 32 ns clock; gap stretches the train into batches
  task automatic xfer(input logic [BAPC_WORD_W-1:0] tx, input bit gap,
                      output logic [BAPC_WORD_W-1:0] rx);
    o_cs_n = 1'b0;
    #16;
    for (int i = BAPC_WORD_W - 1; i >= 0; i--) begin
      o_sclk = ~i_clock_polarity_select;
      #4 o_din = tx[i];
      #12 rx[i] = i_dout;
      o_sclk = i_clock_polarity_select;
      #16;
      if (gap && (i % 3 == 0)) begin
        #120;
      end
    end
    o_cs_n = 1'b1;
    o_din  = ~o_din; // released line must not echo the last bit
  endtask : xfer
endmodule : bapc_host_model

// ### dv/bapc_top_tb.sv
// self-checking testbench for the bridge converter pin control block
`timescale 1ns/1ns
module bapc_top_tb;
  import bapc_pkg::*;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   polarity = 1'b0;
  logic                   reset_n = 1'b1;
  logic                   sync_n = 1'b1;
  logic                   stby_n = 1'b1;
  logic [BAPC_WORD_W-1:0] result = 8'h00;
  logic [BAPC_WORD_W-1:0] rx;
  logic                   sclk, cs_n, din, dout, dout_oe_n, drdy_n, mclk, mclk_oe_n;
  logic                   gp1, gp0, gp_oe_n, exc, exc_c, filt_rst, mod_rst, apwr;
  int                     mismatches = 0;
  int                     samples_checked = 0;

  always #5 clk = ~clk;

  bapc_host_model host (.i_clock_polarity_select(polarity), .i_dout(dout), .o_sclk(sclk),
                        .o_cs_n(cs_n), .o_din(din));
  bapc_top dut (.i_sys_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_clock_polarity_select(polarity),
    .i_cs_n(cs_n), .i_din(din), .i_reset_n(reset_n), .i_filter_sync_n(sync_n),
    .i_standby_n(stby_n), .i_result(result), .o_dout(dout), .o_dout_oe_n(dout_oe_n),
    .o_data_ready_n(drdy_n), .o_mclk_out(mclk), .o_mclk_out_oe_n(mclk_oe_n),
    .o_gp_out_one(gp1), .o_gp_out_zero(gp0), .o_gp_oe_n(gp_oe_n), .o_excite_reverse(exc),
    .o_excite_reverse_cmp(exc_c), .o_filter_reset(filt_rst), .o_modulator_reset(mod_rst),
    .o_analog_power_en(apwr));

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  // mode write; new mode lands a few master cycles after the frame
  task automatic wr(input logic [7:0] b, input bit gap);
    host.xfer(b, gap, rx);
    repeat (8) @(negedge clk);
  endtask : wr

  // bounded wait for a data-ready level; a timeout ends the run
  task automatic wait_drdy(input logic v, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(negedge clk);
      if (drdy_n === v) return;
    end
    chk(1'b0, "data ready wait timed out");
    test_done();
  endtask : wait_drdy

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_gpio();
    wr(8'h12, 1'b0);
    chk(gp_oe_n === 1'b0 && gp1 === 1'b1 && gp0 === 1'b0, "gp pins pol low");
    @(posedge clk) polarity <= 1'b1;
    repeat (4) @(negedge clk);
    wr(8'h11, 1'b1);
    chk(gp1 === 1'b0 && gp0 === 1'b1, "gp pins pol high gapped");
    @(posedge clk) polarity <= 1'b0;
    repeat (4) @(negedge clk);
  endtask : t_gpio

  task automatic t_mclk();
    @(posedge clk) #2;
    chk(mclk === 1'b0 && mclk_oe_n === 1'b0, "mclk not inverted low");
    @(negedge clk) #2;
    chk(mclk === 1'b1, "mclk not inverted high");
    wr(8'h20, 1'b0);
    chk(mclk_oe_n === 1'b1, "mclk still driven");
  endtask : t_mclk

  task automatic t_convert();
    @(posedge clk) result <= 8'ha5;
    wr(8'h04, 1'b0);
    wait_drdy(1'b0, 260);
    host.xfer(8'h04, 1'b0, rx);
    chk(rx === 8'ha5, "read word wrong");
    repeat (6) @(negedge clk);
    chk(drdy_n === 1'b1, "ready not cleared by read");
  endtask : t_convert

  task automatic t_sync();
    wait_drdy(1'b0, 260);
    @(posedge clk) sync_n <= 1'b0;
    repeat (4) @(negedge clk);
    chk(drdy_n === 1'b1, "sync did not force ready high");
    chk(filt_rst === 1'b1 && mod_rst === 1'b1, "sync did not hold reset");
    @(posedge clk) result <= 8'h3c;
    wr(8'h04, 1'b0);
    repeat (250) @(negedge clk);
    chk(drdy_n === 1'b1, "operation ran during sync");
    @(posedge clk) sync_n <= 1'b1;
    // a full update period must restart at release, not carry on from sync
    repeat (190) @(negedge clk);
    chk(drdy_n === 1'b1, "update too early after sync release");
    wait_drdy(1'b0, 25);
    chk(filt_rst === 1'b0, "filter held after sync release");
    host.xfer(8'h04, 1'b0, rx);
    chk(rx === 8'h3c, "word after sync wrong");
  endtask : t_sync

  task automatic t_excite();
    int dead;
    int run;
    bit full;
    dead = 0;
    run = 0;
    full = 1'b0;
    wr(8'hc4, 1'b0);
    // a run bounded by dead cycles on both sides is a complete half period
    for (int k = 0; k < 450; k++) begin
      @(negedge clk);
      chk(!(exc === 1'b1 && exc_c === 1'b1), "excitation overlap");
      if (exc === 1'b0 && exc_c === 1'b0) begin
        if (full && dead == 0) chk(run == 100, "half period length");
        dead++;
        run = 0;
        full = 1'b1;
      end else begin
        if (dead != 0) chk(dead == 1, "dead time not one cycle");
        chk(exc !== exc_c, "outputs not in anti-phase");
        dead = 0;
        run++;
      end
    end
    wr(8'h84, 1'b0);
    repeat (4) @(negedge clk);
    chk(exc === 1'b1 && exc_c === 1'b0, "excitation not parked");
  endtask : t_excite

  task automatic t_standby();
    wr(8'h12, 1'b0);
    @(posedge clk) stby_n <= 1'b0;
    repeat (5) @(negedge clk);
    chk(apwr === 1'b0 && mod_rst === 1'b1, "standby did not stop circuitry");
    chk(gp1 === 1'b1 && gp0 === 1'b0 && gp_oe_n === 1'b0, "mode lost in standby");
    @(posedge clk) stby_n <= 1'b1;
    repeat (5) @(negedge clk);
    chk(gp1 === 1'b1 && gp_oe_n === 1'b0, "mode lost after standby");
  endtask : t_standby

  task automatic t_pin_reset();
    @(posedge clk) reset_n <= 1'b0;
    repeat (5) @(negedge clk);
    chk(gp_oe_n === 1'b1 && gp1 === 1'b0 && gp0 === 1'b0, "pin reset kept mode");
    chk(drdy_n === 1'b1 && exc === 1'b1 && exc_c === 1'b0, "pin reset outputs");
    @(posedge clk) reset_n <= 1'b1;
    repeat (6) @(negedge clk);
  endtask : t_pin_reset

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(negedge clk);
    chk(drdy_n === 1'b1 && gp_oe_n === 1'b1 && mclk_oe_n === 1'b0, "reset state");
    chk(exc === 1'b1 && exc_c === 1'b0, "reset excitation");
    t_gpio();
    t_mclk();
    t_convert();
    t_sync();
    t_excite();
    t_standby();
    t_pin_reset();
    test_done();
  end
endmodule : bapc_top_tb

// ### src/bapc_pkg.sv
// shared constants and types for the bridge converter pin control block
package bapc_pkg;

  // ----------------------------------------------------------------------
  // serial word and mode byte layout
  // ----------------------------------------------------------------------
  localparam int          BAPC_WORD_W        = 8;
  localparam int          BAPC_BITCNT_W      = 4;
  localparam logic [3:0]  BAPC_BITS_PER_WORD = 4'h8;
  localparam int          BAPC_MODE_ACEX_POS = 7;
  localparam int          BAPC_MODE_CHOP_POS = 6;
  localparam int          BAPC_MODE_CKD_POS  = 5;
  localparam int          BAPC_MODE_DOE_POS  = 4;
  localparam int          BAPC_MODE_OP_POS   = 2;
  localparam int          BAPC_MODE_GP1_POS  = 1;
  localparam int          BAPC_MODE_GP0_POS  = 0;
  localparam logic [7:0]  BAPC_MODE_RST      = 8'h00;
  localparam logic [7:0]  BAPC_DATA_RST      = 8'h00;
  localparam logic [1:0]  BAPC_OP_IDLE       = 2'h0;
  localparam logic [1:0]  BAPC_OP_CONVERT    = 2'h1;

  // ----------------------------------------------------------------------
  // timing: times in ns, counts derived from the 100 MHz master clock
  // ----------------------------------------------------------------------
  localparam int          BAPC_SYS_PERIOD_NS  = 10;
  localparam int          BAPC_UPDATE_NS      = 2000;
  localparam int          BAPC_EXC_HALF_NS    = 1000;
  localparam int          BAPC_CNT_W          = 16;
  localparam logic [15:0] BAPC_UPDATE_CYCLES  =
    16'(BAPC_UPDATE_NS / BAPC_SYS_PERIOD_NS);
  localparam logic [15:0] BAPC_EXC_HALF_CYC   =
    16'(BAPC_EXC_HALF_NS / BAPC_SYS_PERIOD_NS);
  localparam logic [15:0] BAPC_CNT_ONE        = 16'h0001;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       ac_excitation_enable;
    logic       chop_enable;
    logic       clock_output_disable;
    logic       digital_output_enable;
    logic [1:0] op_mode;
    logic       gp_out_one;
    logic       gp_out_zero;
  } bapc_mode_s;

  // excitation sequencer, one-hot
  typedef enum logic [3:0] {
    BAPC_EXC_NORM   = 4'h1,
    BAPC_EXC_DEAD_R = 4'h2,
    BAPC_EXC_REV    = 4'h4,
    BAPC_EXC_DEAD_N = 4'h8
  } bapc_exc_e;

endpackage : bapc_pkg

// ### src/bapc_serial_link.sv
// serial link logic running on the host serial clock
`timescale 1ns/1ns
module bapc_serial_link
  import bapc_pkg::*;
(
  input  wire logic                   i_sclk,
  input  wire logic                   i_clock_polarity_select,
  input  wire logic                   i_rst,
  input  wire logic                   i_cs_n,
  input  wire logic                   i_din,
  input  wire logic [BAPC_WORD_W-1:0] i_tx_word,
  output logic                        o_dout,
  output logic                        o_dout_oe_n,
  output logic [BAPC_WORD_W-1:0]      o_rx_word,
  output logic                        o_rx_tgl,
  output logic                        o_rd_tgl
);

  // ----------------------------------------------------------------------
  // edge selection
  // ----------------------------------------------------------------------
  // polarity is a static strap; xor turns the active edge into a falling
  // edge of sclk_smp and the sampling edge into its rising edge
  logic sclk_smp;
  assign sclk_smp = i_sclk ^ ~i_clock_polarity_select;

  // ----------------------------------------------------------------------
  // write side: sample on the edge opposite the active edge
  // ----------------------------------------------------------------------
  logic [BAPC_BITCNT_W-1:0] rcnt_q, rcnt_d;
  logic [BAPC_WORD_W-1:0]   rsh_q, rsh_d, rword_q, rword_d;
  logic                     rtgl_q, rtgl_d;

  // counts survive gaps in the clock, so bursts of any size assemble a word
  always_comb begin
    rsh_d   = {rsh_q[BAPC_WORD_W-2:0], i_din};
    rcnt_d  = rcnt_q + 4'h1;
    rword_d = rword_q;
    rtgl_d  = rtgl_q;
    if (rcnt_d == BAPC_BITS_PER_WORD) begin
      rcnt_d  = '0;
      rword_d = rsh_d;
      rtgl_d  = ~rtgl_q;
    end
  end

  // frame end clears only the bit count, the last word stays for the crossing
  always_ff @(posedge sclk_smp or posedge i_rst or posedge i_cs_n) begin
    if (i_rst) begin
      rcnt_q  <= '0;
    end else if (i_cs_n) begin
      rcnt_q  <= '0;
    end else begin
      rcnt_q  <= rcnt_d;
    end
  end

  // data flops carry only the link reset; an idle edge cannot finish a
  // word because the bit count is pinned at zero while the frame is closed
  always_ff @(posedge sclk_smp or posedge i_rst) begin
    if (i_rst) begin
      rsh_q   <= '0;
      rword_q <= '0;
      rtgl_q  <= 1'b0;
    end else begin
      rsh_q   <= rsh_d;
      rword_q <= rword_d;
      rtgl_q  <= rtgl_d;
    end
  end

  // ----------------------------------------------------------------------
  // read side: drive on the active edge
  // ----------------------------------------------------------------------
  logic [BAPC_BITCNT_W-1:0] dcnt_q, dcnt_d;
  logic [BAPC_WORD_W-1:0]   tsh_q, tsh_d;
  logic                     dout_q, dout_d, oe_n_q, dtgl_q, dtgl_d;

  // the word is taken from the master side on the first active edge of each word; later updates do not reach it
  always_comb begin
    dcnt_d = dcnt_q + 4'h1;
    dtgl_d = dtgl_q;
    if (dcnt_q == '0) begin
      dout_d = i_tx_word[BAPC_WORD_W-1];
      tsh_d  = {i_tx_word[BAPC_WORD_W-2:0], 1'b0};
    end else begin
      dout_d = tsh_q[BAPC_WORD_W-1];
      tsh_d  = {tsh_q[BAPC_WORD_W-2:0], 1'b0};
    end
    if (dcnt_d == BAPC_BITS_PER_WORD) begin
      dcnt_d = '0;
      dtgl_d = ~dtgl_q;
    end
  end

  // count and enable are the only flops that frame end clears
  always_ff @(negedge sclk_smp or posedge i_rst or posedge i_cs_n) begin
    if (i_rst) begin
      dcnt_q <= '0;
      oe_n_q <= 1'b1;
    end else if (i_cs_n) begin
      dcnt_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      dcnt_q <= dcnt_d;
      oe_n_q <= 1'b0;
    end
  end

  // an idle edge only reloads the released pin and the shift register, the read toggle cannot move
  always_ff @(negedge sclk_smp or posedge i_rst) begin
    if (i_rst) begin
      tsh_q  <= '0;
      dout_q <= 1'b0;
      dtgl_q <= 1'b0;
    end else begin
      tsh_q  <= tsh_d;
      dout_q <= dout_d;
      dtgl_q <= dtgl_d;
    end
  end

  assign o_dout      = dout_q;
  assign o_dout_oe_n = oe_n_q;
  assign o_rx_word   = rword_q;
  assign o_rx_tgl    = rtgl_q;
  assign o_rd_tgl    = dtgl_q;

endmodule : bapc_serial_link

// ### src/bapc_top.sv
// pin-level control of the bridge converter: sync, reset, clock out, excitation
`timescale 1ns/1ns

module bapc_top
  import bapc_pkg::*;
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_sclk,
  input  wire logic                   i_clock_polarity_select,
  input  wire logic                   i_cs_n,
  input  wire logic                   i_din,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_filter_sync_n,
  input  wire logic                   i_standby_n,
  input  wire logic [BAPC_WORD_W-1:0] i_result,
  output logic                        o_dout,
  output logic                        o_dout_oe_n,
  output logic                        o_data_ready_n,
  output logic                        o_mclk_out,
  output logic                        o_mclk_out_oe_n,
  output logic                        o_gp_out_one,
  output logic                        o_gp_out_zero,
  output logic                        o_gp_oe_n,
  output logic                        o_excite_reverse,
  output logic                        o_excite_reverse_cmp,
  output logic                        o_filter_reset,
  output logic                        o_modulator_reset,
  output logic                        o_analog_power_en
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rstn_s_q, rstn_s_d, sync_s_q, sync_s_d, stby_s_q, stby_s_d;
  logic [2:0] rxt_s_q, rxt_s_d, rdt_s_q, rdt_s_d;
  logic       rx_tgl, rd_tgl;

  // stage 0 is read only by stage 1; toggles get a third stage for edges
  always_comb begin
    rstn_s_d = {rstn_s_q[0], i_reset_n};
    sync_s_d = {sync_s_q[0], i_filter_sync_n};
    stby_s_d = {stby_s_q[0], i_standby_n};
    rxt_s_d  = {rxt_s_q[1:0], rx_tgl};
    rdt_s_d  = {rdt_s_q[1:0], rd_tgl};
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rstn_s_q <= 2'h0;
      sync_s_q <= 2'h0;
      stby_s_q <= 2'h0;
      rxt_s_q  <= 3'h0;
      rdt_s_q  <= 3'h0;
    end else begin
      rstn_s_q <= rstn_s_d;
      sync_s_q <= sync_s_d;
      stby_s_q <= stby_s_d;
      rxt_s_q  <= rxt_s_d;
      rdt_s_q  <= rdt_s_d;
    end
  end

  logic soft_rst, sync_act, standby, rx_evt, rd_evt;
  assign soft_rst = ~rstn_s_q[1];
  assign sync_act = ~sync_s_q[1];
  assign standby  = ~stby_s_q[1];
  assign rx_evt   = rxt_s_q[2] ^ rxt_s_q[1];
  assign rd_evt   = rdt_s_q[2] ^ rdt_s_q[1];

  // ----------------------------------------------------------------------
  // serial link in the sclk domain
  // ----------------------------------------------------------------------
  logic                   link_rst_q;
  logic [BAPC_WORD_W-1:0] rx_word, data_q, data_d;

  // link reset comes from a flop so a glitch on the pin cannot reach it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      link_rst_q <= 1'b1;
    end else begin
      link_rst_q <= soft_rst;
    end
  end

  bapc_serial_link u_link (
    .i_sclk      (i_sclk),
    .i_clock_polarity_select (i_clock_polarity_select),
    .i_rst       (link_rst_q),
    .i_cs_n      (i_cs_n),
    .i_din       (i_din),
    .i_tx_word   (data_q),
    .o_dout      (o_dout),
    .o_dout_oe_n (o_dout_oe_n),
    .o_rx_word   (rx_word),
    .o_rx_tgl    (rx_tgl),
    .o_rd_tgl    (rd_tgl)
  );

  // ----------------------------------------------------------------------
  // mode byte and run state
  // ----------------------------------------------------------------------
  bapc_mode_s mode_q, mode_d;
  logic       run_q, run_d;

  // a write during sync lands in the mode byte at once but the run gate
  // stays shut until sync is released; standby freezes nothing stored
  always_comb begin
    mode_d = mode_q;
    if (rx_evt) begin
      mode_d = bapc_mode_s'(rx_word);
    end
    run_d = ~sync_act & ~standby & (mode_q.op_mode == BAPC_OP_CONVERT);
    if (soft_rst) begin
      mode_d = bapc_mode_s'(BAPC_MODE_RST);
      run_d  = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= bapc_mode_s'(BAPC_MODE_RST);
      run_q  <= 1'b0;
    end else begin
      mode_q <= mode_d;
      run_q  <= run_d;
    end
  end

  // ----------------------------------------------------------------------
  // output updates and data-ready
  // ----------------------------------------------------------------------
  logic [BAPC_CNT_W-1:0] ucnt_q, ucnt_d;
  logic                  rdy_n_q, rdy_n_d, upd;

  // an update that meets a read completion wins, so new data is not hidden
  always_comb begin
    upd     = run_q & (ucnt_q == BAPC_CNT_ONE);
    ucnt_d  = run_q ? (upd ? BAPC_UPDATE_CYCLES : ucnt_q - BAPC_CNT_ONE)
                    : BAPC_UPDATE_CYCLES;
    data_d  = upd ? i_result : data_q;
    rdy_n_d = rdy_n_q;
    if (rd_evt) begin
      rdy_n_d = 1'b1;
    end
    if (upd) begin
      rdy_n_d = 1'b0;
    end
    if (sync_act) begin
      rdy_n_d = 1'b1;
    end
    if (soft_rst) begin
      ucnt_d  = BAPC_UPDATE_CYCLES;
      data_d  = BAPC_DATA_RST;
      rdy_n_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ucnt_q  <= BAPC_UPDATE_CYCLES;
      data_q  <= BAPC_DATA_RST;
      rdy_n_q <= 1'b1;
    end else begin
      ucnt_q  <= ucnt_d;
      data_q  <= data_d;
      rdy_n_q <= rdy_n_d;
    end
  end

  // ----------------------------------------------------------------------
  // excitation reversal sequencer
  // ----------------------------------------------------------------------
  bapc_exc_e             exc_q, exc_d;
  logic [BAPC_CNT_W-1:0] ecnt_q, ecnt_d;
  logic                  exc_allow, half_done;

  // dead states last one master cycle and run to completion unless the reset pin acts, so the
  // pair can never overlap even when ac mode is switched off mid-swap
  always_comb begin
    exc_allow = mode_q.ac_excitation_enable & mode_q.chop_enable & run_q;
    half_done = (ecnt_q == BAPC_CNT_ONE);
    ecnt_d    = half_done ? BAPC_EXC_HALF_CYC : ecnt_q - BAPC_CNT_ONE;
    exc_d     = exc_q;
    unique case (exc_q)
      BAPC_EXC_NORM: begin
        if (!exc_allow) begin
          ecnt_d = BAPC_EXC_HALF_CYC;
        end else if (half_done) begin
          exc_d = BAPC_EXC_DEAD_R;
        end
      end
      BAPC_EXC_DEAD_R: begin
        exc_d  = BAPC_EXC_REV;
        ecnt_d = BAPC_EXC_HALF_CYC; // dead cycle is not part of the half period
      end
      BAPC_EXC_REV: begin
        if (!exc_allow || half_done) begin
          exc_d = BAPC_EXC_DEAD_N;
        end
      end
      BAPC_EXC_DEAD_N: begin
        exc_d  = BAPC_EXC_NORM;
        ecnt_d = BAPC_EXC_HALF_CYC;
      end
      default: begin
        exc_d = BAPC_EXC_NORM;
      end
    endcase
    if (soft_rst) begin
      exc_d  = BAPC_EXC_NORM;
      ecnt_d = BAPC_EXC_HALF_CYC;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      exc_q  <= BAPC_EXC_NORM;
      ecnt_q <= BAPC_EXC_HALF_CYC;
    end else begin
      exc_q  <= exc_d;
      ecnt_q <= ecnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // registered pin outputs
  // ----------------------------------------------------------------------
  logic exr_q, exr_d, exrc_q, exrc_d, ckoe_n_q, ckoe_n_d;
  logic gp1_q, gp1_d, gp0_q, gp0_d, gpoe_n_q, gpoe_n_d;
  logic frst_q, frst_d, mrst_q, mrst_d, apwr_q, apwr_d;

  always_comb begin
    exr_d    = (exc_d == BAPC_EXC_NORM);
    exrc_d   = (exc_d == BAPC_EXC_REV);
    ckoe_n_d = mode_d.clock_output_disable;
    gp1_d    = mode_d.gp_out_one;
    gp0_d    = mode_d.gp_out_zero;
    gpoe_n_d = ~mode_d.digital_output_enable;
    frst_d   = sync_act | soft_rst;
    mrst_d   = sync_act | soft_rst | standby;
    apwr_d   = ~standby;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      exr_q    <= 1'b1;
      exrc_q   <= 1'b0;
      ckoe_n_q <= 1'b0;
      gp1_q    <= 1'b0;
      gp0_q    <= 1'b0;
      gpoe_n_q <= 1'b1;
      frst_q   <= 1'b1;
      mrst_q   <= 1'b1;
      apwr_q   <= 1'b0;
    end else begin
      exr_q    <= exr_d;
      exrc_q   <= exrc_d;
      ckoe_n_q <= ckoe_n_d;
      gp1_q    <= gp1_d;
      gp0_q    <= gp0_d;
      gpoe_n_q <= gpoe_n_d;
      frst_q   <= frst_d;
      mrst_q   <= mrst_d;
      apwr_q   <= apwr_d;
    end
  end

  // the inverted clock cannot come from a flop; the gate is registered so
  // the output only stops or starts while the master clock is high
  assign o_mclk_out           = ~i_sys_clk & ~ckoe_n_q;
  assign o_mclk_out_oe_n      = ckoe_n_q;
  assign o_data_ready_n       = rdy_n_q;
  assign o_gp_out_one         = gp1_q;
  assign o_gp_out_zero        = gp0_q;
  assign o_gp_oe_n            = gpoe_n_q;
  assign o_excite_reverse     = exr_q;
  assign o_excite_reverse_cmp = exrc_q;
  assign o_filter_reset       = frst_q;
  assign o_modulator_reset    = mrst_q;
  assign o_analog_power_en    = apwr_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_EXC_NO_OVERLAP: assert property (!(o_excite_reverse && o_excite_reverse_cmp))
    else $error("excitation outputs high together");
  AST_EXC_DEAD: assert property ($fell(o_excite_reverse) |->
      !o_excite_reverse_cmp ##1 o_excite_reverse_cmp)
    else $error("dead time before reverse is not one cycle");
  AST_EXC_IDLE: assert property (!exc_allow && exc_q == BAPC_EXC_NORM |=>
      o_excite_reverse && !o_excite_reverse_cmp)
    else $error("excitation not idle with ac or chop off");
  AST_RDY_SYNC: assert property (sync_act |=> o_data_ready_n)
    else $error("data-ready low during filter sync");
  AST_RDY_READ: assert property (rd_evt && !upd |=> o_data_ready_n)
    else $error("data-ready not released after full read");
  AST_FILT_RST: assert property (sync_act |=> o_filter_reset && o_modulator_reset && !run_q)
    else $error("filter not held in reset during sync");
  AST_MODE_WAIT: assert property (sync_act [*3] |-> ucnt_q == BAPC_UPDATE_CYCLES)
    else $error("conversion ran during filter sync");
  AST_SOFT_RST: assert property (soft_rst |=>
      mode_q == bapc_mode_s'(BAPC_MODE_RST) && o_data_ready_n)
    else $error("reset pin did not clear state");
  AST_GP_OUT: assert property (mode_q.digital_output_enable |->
      !o_gp_oe_n && o_gp_out_one == mode_q.gp_out_one && o_gp_out_zero == mode_q.gp_out_zero)
    else $error("gp pins do not follow mode bits");
  AST_CLK_OFF: assert property (mode_q.clock_output_disable |-> o_mclk_out_oe_n)
    else $error("clock output not stopped");
  AST_STANDBY: assert property (standby && !rx_evt && !soft_rst |=> $stable(mode_q))
    else $error("mode byte lost in standby");

  COV_EXC_SWAP: cover property ($rose(o_excite_reverse_cmp));
  COV_READ_DONE: cover property (!o_data_ready_n ##1 rd_evt);
  COV_SYNC_RELEASE: cover property ($fell(sync_act) ##[1:300] upd);

endmodule : bapc_top
